// ---- verilog/spi_core_consts.svh ----
// constants of the serial peripheral core: register map, field positions, reset values, timing
// Function
// (RQ1) transmit holding and shift registers are n bits wide, n from 1 to 16
// (RQ2) receive holding and shift registers are n bits wide, same n
// (RQ3) holding value moves to transmit shift register whenever no shift is running
// (RQ4) finished shift copies receive shift register into receive holding register
// (RQ5) transmit shift register drives mosi as master, miso as slave
// (RQ6) receive shift register loads from miso as master, mosi as slave
// (RQ7) bits shift least or most significant first per build setting
// (RQ8) master or slave role fixed at build time
// (RQ9) master has one active-low select per target, 0 to 15, count fixed at build
// (RQ10) master asserts select of every target named in target-select register
// (RQ11) host names at most one driving target per transfer
// (RQ12) master-mode write to transmit holding register starts a transfer
// (RQ13) full duplex: each active clock edge moves one bit each way
// (RQ14) master divides system clock for serial clock; all logic on system clock
// (RQ15) slave receive logic follows the external serial clock
// (RQ16) slave starts shifting as soon as select input goes low
// (RQ17) slave sends host-written data in the next transfer the master starts
// (RQ18) maskable interrupts for received data and transmit ready
// (RQ19) status register shows transfer progress
// (RQ20) unselected slave drives miso to an undefined level, never high impedance
// (RQ21) single register port with flow-control signals for streaming
// (RQ22) serial clock idles low with polarity 0, high with polarity 1
// (RQ23) phase 0 latches leading edge, phase 1 latches trailing edge
// (RQ24) serial clock is system clock divided by an even divisor
// (RQ25) optional select-to-data delay rounded up to half serial periods
// (RQ26) reset deasserts selects, idles clock, abandons shift, clears pending flags
`ifndef SPI_CORE_CONSTS_SVH
`define SPI_CORE_CONSTS_SVH

`define SPI_ADDR_RXDATA 3'h0
`define SPI_ADDR_TXDATA 3'h1
`define SPI_ADDR_STATUS 3'h2
`define SPI_ADDR_CONTROL 3'h3
`define SPI_ADDR_TARGET 3'h5

`define SPI_ST_ROE 3
`define SPI_ST_TOE 4
`define SPI_ST_TMT 5
`define SPI_ST_TRDY 6
`define SPI_ST_RRDY 7
`define SPI_ST_ERR 8

`define SPI_CONTROL_RESET 16'h0000
`define SPI_TARGET_RESET 16'h0001

`define SPI_SYS_PERIOD_NS 50
`define SPI_CLK_DIV 2
`define SPI_SEL_DELAY_NS 0

`endif

// ---- verilog/spi_core_pkg.sv ----
// types shared by the serial peripheral core
package spi_core_pkg;
   typedef enum logic [1:0] {M_IDLE, M_LEAD, M_SHIFT, M_TAIL} master_state_e;
endpackage : spi_core_pkg

// ---- verilog/spi_core.sv ----
// serial peripheral core, master or slave by build parameter, with register port
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`include "spi_core_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module spi_core
   import spi_core_pkg::*;
#(
   parameter bit MASTER = 1'b1,
   parameter int WIDTH = 8,
   parameter int NUM_TARGETS = 1,
   parameter bit LSB_FIRST = 1'b0,
   parameter bit CPOL = 1'b0,
   parameter bit CPHA = 1'b0,
   parameter int CLK_DIV = `SPI_CLK_DIV,
   parameter int SEL_DELAY_NS = `SPI_SEL_DELAY_NS
) (
   input wire logic MCLK,
   input wire logic SRST,
   input wire logic CE,
   input wire logic [2:0] ADDR,
   input wire logic [15:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [15:0] RDATA,
   output logic DATA_AVAIL,
   output logic READY_FOR_DATA,
   output logic IRQ,
   output logic SCLK_OUT,
   output logic MOSI_OUT,
   input wire logic MISO_IN,
   output logic [NUM_TARGETS-1:0] PER_TARGET_SELECT_LINE_N,
   input wire logic SCLK_IN,
   input wire logic MOSI_IN,
   input wire logic SEL_N_IN,
   output logic MISO_OUT
);
   // half serial period in system cycles; an odd divisor cannot give a symmetric clock
   localparam int HALF = (CLK_DIV < 2) ? 1 : CLK_DIV / 2; // RQ24
   localparam int HALF_NS = HALF * `SPI_SYS_PERIOD_NS;
   localparam int DELAY_HALVES = (SEL_DELAY_NS + HALF_NS - 1) / HALF_NS; // RQ25
   localparam int EDGES = 2 * WIDTH;
   localparam logic [7:0] HALF_LAST = 8'(HALF - 1);
   localparam logic [5:0] EDGE_LAST = 6'(EDGES - 1);
   localparam logic [7:0] DELAY_LAST = 8'((DELAY_HALVES > 0) ? DELAY_HALVES - 1 : 0);
   localparam logic [4:0] BITS = 5'(WIDTH);

   function automatic logic [WIDTH-1:0] shift_in(input logic [WIDTH-1:0] v, input logic b);
      logic [WIDTH-1:0] r;
      r = LSB_FIRST ? (v >> 1) : (v << 1); // RQ7
      r[LSB_FIRST ? WIDTH-1 : 0] = b;
      return r;
   endfunction : shift_in

   function automatic logic [WIDTH-1:0] shift_out(input logic [WIDTH-1:0] v);
      return LSB_FIRST ? (v >> 1) : (v << 1); // RQ7
   endfunction : shift_out

   // registers
   logic [WIDTH-1:0] tx_hold; // RQ1
   logic [WIDTH-1:0] tx_shift; // RQ1
   logic [WIDTH-1:0] rx_hold; // RQ2
   logic [WIDTH-1:0] rx_shift; // RQ2
   logic tx_pend;
   logic rrdy;
   logic roe;
   logic toe;
   logic [15:0] control;
   logic [NUM_TARGETS-1:0] target_sel;
   logic done;
   logic busy;
   logic load_tx;
   logic shift_edge;
   logic sample_edge;
   logic in_bit;
   logic out_bit;

   // master engine
   master_state_e state;
   logic [7:0] div_cnt;
   logic [5:0] edge_cnt;
   logic [7:0] lead_cnt;
   logic sclk;
   logic half_tick;

   // slave pin synchronisers
   logic sclk_s1, sclk_s2, sclk_s3;
   logic mosi_s1, mosi_s2;
   logic sel_s1, sel_s2;
   logic [4:0] bit_cnt;

   wire logic wr_tx = WR && ADDR == `SPI_ADDR_TXDATA;
   wire logic rd_rx = RD && ADDR == `SPI_ADDR_RXDATA;
   wire logic tmt = !tx_pend && !busy;

   assign out_bit = tx_shift[LSB_FIRST ? 0 : WIDTH-1];
   assign half_tick = div_cnt == HALF_LAST;

   // serial timing, shared by both roles
   always_comb begin
      if (MASTER) begin // RQ8
         in_bit = MISO_IN; // RQ6
         busy = state != M_IDLE;
         load_tx = state == M_IDLE && tx_pend; // RQ3 RQ12
         // even edge index is leading, odd is trailing
         sample_edge = state == M_SHIFT && half_tick && (edge_cnt[0] == CPHA); // RQ23
         shift_edge = state == M_SHIFT && half_tick && (edge_cnt[0] != CPHA) && edge_cnt != 6'h00; // RQ13
         done = state == M_TAIL && half_tick;
      end else begin
         in_bit = mosi_s2; // RQ6
         busy = !sel_s2 && bit_cnt != 5'h00;
         load_tx = !busy && tx_pend; // RQ3 RQ17
         sample_edge = !sel_s2 && sclk_s2 != sclk_s3 && ((sclk_s3 == CPOL) != CPHA); // RQ15 RQ23
         shift_edge = !sel_s2 && sclk_s2 != sclk_s3 && ((sclk_s3 == CPOL) == CPHA) && bit_cnt != 5'h00;
         done = sample_edge && bit_cnt == BITS - 5'h01;
      end
   end

   // two flops on every pin that comes from the external master, three on the serial clock
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         sclk_s1 <= CPOL;
         sclk_s2 <= CPOL;
         sclk_s3 <= CPOL;
         mosi_s1 <= 1'b0;
         mosi_s2 <= 1'b0;
         sel_s1 <= 1'b1;
         sel_s2 <= 1'b1;
      end else if (CE) begin
         sclk_s1 <= SCLK_IN; // RQ15
         sclk_s2 <= sclk_s1;
         sclk_s3 <= sclk_s2;
         mosi_s1 <= MOSI_IN;
         mosi_s2 <= mosi_s1;
         sel_s1 <= SEL_N_IN; // RQ16
         sel_s2 <= sel_s1;
      end
   end

   // slave bit counter; a deselect abandons the word
   always_ff @(posedge MCLK) begin
      if (SRST || MASTER) begin
         bit_cnt <= 5'h00;
      end else if (CE) begin
         if (sel_s2) begin
            bit_cnt <= 5'h00; // RQ16
         end else if (done) begin
            bit_cnt <= 5'h00;
         end else if (sample_edge) begin
            bit_cnt <= bit_cnt + 5'h01;
         end
      end
   end

   // master sequencer and clock divider
   always_ff @(posedge MCLK) begin
      if (SRST || !MASTER) begin
         state <= M_IDLE; // RQ26
         div_cnt <= 8'h00;
         edge_cnt <= 6'h00;
         lead_cnt <= 8'h00;
         sclk <= CPOL; // RQ22 RQ26
      end else if (CE) begin
         div_cnt <= (state == M_IDLE || half_tick) ? 8'h00 : div_cnt + 8'h01;
         case (state)
            M_IDLE: begin
               edge_cnt <= 6'h00;
               lead_cnt <= 8'h00;
               sclk <= CPOL; // RQ22
               if (load_tx) begin
                  state <= (DELAY_HALVES > 0) ? M_LEAD : M_SHIFT; // RQ12 RQ25
               end
            end
            M_LEAD: begin
               if (half_tick) begin
                  lead_cnt <= lead_cnt + 8'h01;
                  if (lead_cnt == DELAY_LAST) begin
                     state <= M_SHIFT; // RQ25
                  end
               end
            end
            M_SHIFT: begin
               if (half_tick) begin
                  sclk <= !sclk; // RQ14
                  edge_cnt <= edge_cnt + 6'h01;
                  if (edge_cnt == EDGE_LAST) begin
                     state <= M_TAIL;
                  end
               end
            end
            M_TAIL: begin
               if (half_tick) begin
                  state <= M_IDLE;
               end
            end
            default: begin
               state <= M_IDLE;
            end
         endcase
      end
   end

   // shift registers
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         tx_shift <= '0; // RQ26
         rx_shift <= '0;
      end else if (CE) begin
         if (load_tx) begin
            tx_shift <= tx_hold; // RQ3
         end else if (shift_edge) begin
            tx_shift <= shift_out(tx_shift); // RQ5 RQ13
         end
         if (sample_edge) begin
            rx_shift <= shift_in(rx_shift, in_bit); // RQ6 RQ13
         end
      end
   end

   // receive holding register; it keeps the old word while the next one shifts in
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         rx_hold <= '0;
      end else if (CE && done) begin
         // slave completion is seen with the last sample still in flight
         rx_hold <= MASTER ? rx_shift : shift_in(rx_shift, in_bit); // RQ4
      end
   end

   // transmit holding register; a write while still full is dropped and flagged
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         tx_hold <= '0;
         tx_pend <= 1'b0; // RQ26
      end else if (CE) begin
         if (wr_tx && !tx_pend) begin
            tx_hold <= WDATA[WIDTH-1:0];
            tx_pend <= 1'b1; // RQ12
         end else if (load_tx) begin
            tx_pend <= 1'b0; // RQ3
         end
      end
   end

   // status flags: a set in the same cycle as a clear wins
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         rrdy <= 1'b0; // RQ26
         roe <= 1'b0;
         toe <= 1'b0;
      end else if (CE) begin
         if (done) begin
            rrdy <= 1'b1; // RQ18 RQ19
         end else if (rd_rx) begin
            rrdy <= 1'b0;
         end
         if (done && rrdy && !rd_rx) begin
            roe <= 1'b1; // RQ19
         end else if (WR && ADDR == `SPI_ADDR_STATUS) begin
            roe <= 1'b0;
         end
         if (wr_tx && tx_pend) begin
            toe <= 1'b1; // RQ19
         end else if (WR && ADDR == `SPI_ADDR_STATUS) begin
            toe <= 1'b0;
         end
      end
   end

   // control and target-select registers
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         control <= `SPI_CONTROL_RESET;
         target_sel <= NUM_TARGETS'(`SPI_TARGET_RESET);
      end else if (CE && WR) begin
         if (ADDR == `SPI_ADDR_CONTROL) begin
            control <= WDATA;
         end
         if (ADDR == `SPI_ADDR_TARGET) begin
            target_sel <= WDATA[NUM_TARGETS-1:0]; // RQ10
         end
      end
   end

   // read data stands for one cycle after the strobe
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         RDATA <= 16'h0000;
      end else if (CE) begin
         RDATA <= 16'h0000;
         if (RD) begin
            case (ADDR)
               `SPI_ADDR_RXDATA: RDATA <= 16'(rx_hold); // RQ21
               `SPI_ADDR_TXDATA: RDATA <= 16'(tx_hold);
               `SPI_ADDR_STATUS: begin
                  RDATA[`SPI_ST_ROE] <= roe;
                  RDATA[`SPI_ST_TOE] <= toe;
                  RDATA[`SPI_ST_TMT] <= tmt; // RQ19
                  RDATA[`SPI_ST_TRDY] <= !tx_pend;
                  RDATA[`SPI_ST_RRDY] <= rrdy;
                  RDATA[`SPI_ST_ERR] <= roe || toe;
               end
               `SPI_ADDR_CONTROL: RDATA <= control;
               `SPI_ADDR_TARGET: RDATA <= 16'(target_sel);
               default: RDATA <= 16'h0000;
            endcase
         end
      end
   end

   // flow control and interrupt come straight from the flags
   assign DATA_AVAIL = rrdy; // RQ21
   assign READY_FOR_DATA = !tx_pend; // RQ21
   assign IRQ = (control[`SPI_ST_ROE] && roe) || (control[`SPI_ST_TOE] && toe) ||
                (control[`SPI_ST_TRDY] && !tx_pend) || (control[`SPI_ST_RRDY] && rrdy) ||
                (control[`SPI_ST_ERR] && (roe || toe)); // RQ18

   // pins; the unused role's outputs rest at idle
   assign SCLK_OUT = MASTER ? sclk : CPOL; // RQ14 RQ22
   assign MOSI_OUT = MASTER ? out_bit : 1'b0; // RQ5
   // unselected slave keeps driving whatever bit sits at the shifter end
   assign MISO_OUT = MASTER ? 1'b0 : out_bit; // RQ5 RQ20
   // host keeps one driving target per transfer; this core does not check it
   assign PER_TARGET_SELECT_LINE_N = (MASTER && busy) ? ~target_sel : '1; // RQ9 RQ10 RQ11

   // checks
   sequence s_start;
      state == M_IDLE && tx_pend;
   endsequence

   sequence s_running;
      state == M_LEAD || state == M_SHIFT;
   endsequence

   a_sel_idle: assert property (@(posedge MCLK) disable iff (SRST) // RQ26
      state == M_IDLE |-> PER_TARGET_SELECT_LINE_N == '1)
      else $error("select asserted while master idle");
   a_sclk_idle: assert property (@(posedge MCLK) disable iff (SRST) // RQ22
      state == M_IDLE |-> SCLK_OUT == CPOL)
      else $error("serial clock not at idle level");
   a_tx_load: assert property (@(posedge MCLK) disable iff (SRST || !CE || !MASTER) // RQ3
      s_start |=> s_running ##0 !tx_pend ##0 tx_shift == $past(tx_hold))
      else $error("holding value not moved to shifter at start");
   a_sel_active: assert property (@(posedge MCLK) disable iff (SRST || !MASTER) // RQ10
      state == M_SHIFT |-> PER_TARGET_SELECT_LINE_N == ~target_sel)
      else $error("select lines differ from target-select register");
   a_rx_copy: assert property (@(posedge MCLK) disable iff (SRST || !CE || !MASTER) // RQ4
      done |=> rx_hold == $past(rx_shift) && rrdy)
      else $error("receive word not copied on completion");
   a_rdata_next: assert property (@(posedge MCLK) disable iff (SRST || !CE) // RQ21
      rd_rx |=> RDATA == 16'($past(rx_hold)))
      else $error("receive read data wrong");
   a_toe_set: assert property (@(posedge MCLK) disable iff (SRST || !CE) // RQ19
      wr_tx && tx_pend |=> toe && tx_hold == $past(tx_hold))
      else $error("write to full holding register not flagged");
   // in M_SHIFT the serial clock may move only on a divider tick, and must move on every one
   a_sclk_half: assert property (@(posedge MCLK) disable iff (SRST || !CE || !MASTER) // RQ24
      state == M_SHIFT |=> $changed(sclk) == $past(half_tick))
      else $error("serial clock changed within a half period");
   a_rx_shift: assert property (@(posedge MCLK) disable iff (SRST || !CE) // RQ6
      sample_edge |=> rx_shift[LSB_FIRST ? WIDTH-1 : 0] == $past(in_bit))
      else $error("sampled bit not taken into receive shifter");
   a_edge_total: assert property (@(posedge MCLK) disable iff (SRST || !MASTER) // RQ13
      state == M_TAIL |-> edge_cnt == EDGE_LAST + 6'h01)
      else $error("frame ended with wrong number of clock edges");
   // old word must survive while the next one shifts in
   a_rx_keep: assert property (@(posedge MCLK) disable iff (SRST) // RQ4
      !(CE && done) |=> $stable(rx_hold))
      else $error("receive holding register changed outside completion");
   a_ce_hold: assert property (@(posedge MCLK) disable iff (SRST) // RQ14
      !CE |=> $stable(tx_pend) && $stable(rrdy) && $stable(state) && $stable(sclk))
      else $error("state moved while clock enable low");
endmodule : spi_core
`default_nettype wire

// ---- tb/spi_target_model.sv ----
// behavioural serial target, clock mode 0, most significant bit first
`timescale 1ns/100ps
`default_nettype none
module spi_target_model #(
   parameter int WIDTH = 8
) (
   input wire logic sclk,
   input wire logic mosi,
   input wire logic sel_n,
   input wire logic [WIDTH-1:0] tx_word,
   output logic miso,
   output logic [WIDTH-1:0] rx_word,
   output logic [7:0] edge_count
);
   logic [WIDTH-1:0] shift_out;
   initial begin
      miso = 1'b0;
      rx_word = '0;
      edge_count = 8'h00;
   end
   // a single target on the line, so only one driver of miso exists
   always @(negedge sel_n) begin
      shift_out = tx_word;
      miso = tx_word[WIDTH-1];
      rx_word = '0;
      edge_count = 8'h00;
   end
   // released line shows the inverse so a stale bit never looks right
   always @(posedge sel_n) begin
      miso = ~miso;
   end
   always @(posedge sclk) begin
      if (!sel_n) begin
         rx_word = {rx_word[WIDTH-2:0], mosi};
         edge_count = edge_count + 8'h01;
      end
   end
   always @(negedge sclk) begin
      if (!sel_n) begin
         shift_out = shift_out << 1;
         miso = shift_out[WIDTH-1];
      end
   end
endmodule : spi_target_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench: master build against a behavioural target
`include "spi_core_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_top
   import spi_core_pkg::*;
;
   localparam int WIDTH = 8;
   localparam int CLK_DIV = 4;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic ce = 1'b1;
   logic [2:0] addr = 3'h0;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [15:0] rdata;
   logic data_avail, ready_for_data, irq, sclk, mosi, miso;
   logic [1:0] sel_n;
   logic [WIDTH-1:0] target_tx = 8'h3c;
   logic [WIDTH-1:0] target_rx;
   logic [7:0] target_edges;
   logic [1:0] exp_sel = 2'b11;
   logic [WIDTH-1:0] frame_q[$];
   logic [15:0] val;
   logic last_sclk = 1'b0;
   logic in_frame = 1'b0;
   int half_cnt = 0;
   int cyc = 0;
   int bad_count = 0;
   int comparisons = 0;
   wire sel_all = &sel_n;
   always #25 mclk = ~mclk;

   spi_core #(.MASTER(1'b1), .WIDTH(WIDTH), .NUM_TARGETS(2), .CLK_DIV(CLK_DIV)) u_dut (
      .MCLK(mclk), .SRST(srst), .CE(ce), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .DATA_AVAIL(data_avail), .READY_FOR_DATA(ready_for_data), .IRQ(irq),
      .SCLK_OUT(sclk), .MOSI_OUT(mosi), .MISO_IN(miso), .PER_TARGET_SELECT_LINE_N(sel_n),
      .SCLK_IN(1'b0), .MOSI_IN(mosi), .SEL_N_IN(1'b1), .MISO_OUT());
   spi_target_model #(.WIDTH(WIDTH)) u_target (.sclk(sclk), .mosi(mosi), .sel_n(sel_all),
      .tx_word(target_tx), .miso(miso), .rx_word(target_rx), .edge_count(target_edges));

   task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_val
   task automatic check_bit(input logic got, input logic exp);
      check_val({15'h0000, got}, {15'h0000, exp});
   endtask : check_bit
   task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [2:0] a, output logic [15:0] d);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask : rd_reg
   task automatic wait_frames(input int n);
      int k;
      k = 0;
      while (frame_q.size() < n && k < 400) begin
         @(posedge mclk);
         k++;
      end
      repeat (4) @(negedge mclk);
      check_val(16'(frame_q.size()), 16'(n));
   endtask : wait_frames
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : close_out

   // each finished frame logs what the target heard
   always @(posedge sel_all) begin
      if (!srst) begin
         frame_q.push_back(target_rx);
         check_val(16'(target_edges), 16'(WIDTH));
      end
   end
   // line watcher: idle clock level, select pattern, half period length
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 5000) begin
         bad_count++;
         close_out;
      end
      half_cnt++;
      if (!srst) begin
         if (sel_all) begin
            check_bit(sclk, 1'b0);
            in_frame = 1'b0;
         end else begin
            check_val(16'(sel_n), 16'(exp_sel));
            if (sclk !== last_sclk) begin
               if (in_frame) check_val(16'(half_cnt), 16'(CLK_DIV / 2));
               in_frame = 1'b1;
               half_cnt = 0;
            end
         end
      end
      last_sclk = sclk;
   end

   initial begin
      repeat (10) @(posedge mclk);
      srst <= 1'b0;
      @(negedge mclk);
      check_val(16'(sel_n), 16'h0003);
      check_bit(ready_for_data, 1'b1);
      check_bit(data_avail, 1'b0);
      check_bit(irq, 1'b0);
      rd_reg(`SPI_ADDR_STATUS, val);
      check_val(val & 16'h01f8, 16'h0060);
      rd_reg(3'h4, val);
      check_val(val, 16'h0000);
      rd_reg(`SPI_ADDR_TARGET, val);
      check_val(val, 16'h0001);
      // one word to target 1, completion masked
      exp_sel = 2'b01;
      wr_reg(`SPI_ADDR_TARGET, 16'h0002);
      wr_reg(`SPI_ADDR_TXDATA, 16'h00a5);
      wait_frames(1);
      check_bit(data_avail, 1'b1);
      check_bit(irq, 1'b0);
      check_val(16'(frame_q.pop_front()), 16'h00a5);
      rd_reg(`SPI_ADDR_RXDATA, val);
      check_val(val, 16'h003c);
      check_bit(data_avail, 1'b0);
      // double buffering, dropped write and overrun to target 0
      exp_sel = 2'b10;
      target_tx = 8'hc3;
      wr_reg(`SPI_ADDR_TARGET, 16'h0001);
      wr_reg(`SPI_ADDR_TXDATA, 16'h0081);
      wr_reg(`SPI_ADDR_TXDATA, 16'h007e);
      @(negedge mclk);
      check_bit(ready_for_data, 1'b0);
      wr_reg(`SPI_ADDR_TXDATA, 16'h00ff);
      wait_frames(2);
      check_val(16'(frame_q.pop_front()), 16'h0081);
      check_val(16'(frame_q.pop_front()), 16'h007e);
      rd_reg(`SPI_ADDR_STATUS, val);
      check_val(val & 16'h0098, 16'h0098);
      rd_reg(`SPI_ADDR_RXDATA, val);
      check_val(val, 16'h00c3);
      wr_reg(`SPI_ADDR_STATUS, 16'h0000);
      rd_reg(`SPI_ADDR_STATUS, val);
      check_val(val & 16'h0018, 16'h0000);
      // interrupt masks
      wr_reg(`SPI_ADDR_CONTROL, 16'h0080);
      wr_reg(`SPI_ADDR_TXDATA, 16'h0055);
      wait_frames(1);
      check_bit(irq, 1'b1);
      check_val(16'(frame_q.pop_front()), 16'h0055);
      rd_reg(`SPI_ADDR_RXDATA, val);
      check_bit(irq, 1'b0);
      wr_reg(`SPI_ADDR_CONTROL, 16'h0040);
      @(negedge mclk);
      check_bit(irq, 1'b1);
      wr_reg(`SPI_ADDR_CONTROL, 16'h0000);
      // a low clock enable freezes the block, so this write is lost
      ce <= 1'b0;
      wr_reg(`SPI_ADDR_TXDATA, 16'h0033);
      @(negedge mclk);
      check_bit(ready_for_data, 1'b1);
      check_bit(sel_all, 1'b1);
      @(posedge mclk);
      ce <= 1'b1;
      repeat (4) @(negedge mclk);
      check_bit(sel_all, 1'b1);
      check_bit(ready_for_data, 1'b1);
      // reset in mid-frame abandons the shift
      wr_reg(`SPI_ADDR_TXDATA, 16'h00f0);
      repeat (8) @(posedge mclk);
      srst <= 1'b1;
      repeat (2) @(posedge mclk);
      srst <= 1'b0;
      @(negedge mclk);
      check_val(16'(sel_n), 16'h0003);
      check_bit(sclk, 1'b0);
      repeat (100) @(negedge mclk);
      check_bit(data_avail, 1'b0);
      check_val(16'(frame_q.size()), 16'h0000);
      close_out;
   end
endmodule : tb_top
`default_nettype wire
